// ---- sto_enable_defs.vh ----
// Constants for the dual-source torque enable logic
`ifndef STO_ENABLE_DEFS_VH
`define STO_ENABLE_DEFS_VH

// Clock rate and documented times
`define STO_CLK_MHZ        50
`define STO_PULSE_US       3500
`define STO_DISC_MS        1000
`define STO_US_PER_MS      1000

// Pulse bridge and discrepancy time as 20 ns cycles, sized to fit
`define STO_PULSE_CYC      26'h2ab98
`define STO_DISC_CYC       26'h2faf080

// Counter width, large enough for the discrepancy count
`define STO_CNT_W          26

// Axes, torque-off paths per axis, switch address width
`define STO_AXES           2
`define STO_PATHS          4
`define STO_ADDR_W         10

// Process image sizes in bytes; held image width in bits
`define STO_PI_BYTES       8'h07
`define STO_PI_USE_BYTES   8'h02
`define STO_PI_W           16

// Register bus
`define STO_RA_W           8
`define STO_RD_W           32
`define STO_REG_CTRL       8'h00
`define STO_REG_STATUS     8'h04
`define STO_REG_ADDR       8'h08
`define STO_REG_PI_IN      8'h0c
`define STO_REG_PI_OUT     8'h10
`define STO_REG_DIAG       8'h14
`define STO_REG_SIZES      8'h18

// Control word bits
`define STO_CW_ACK_BIT     7
`define STO_CW_RESET_BIT   8

// Status word bits
`define STO_ST_FB_A_BIT    0
`define STO_ST_FB_B_BIT    1
`define STO_ST_ERR_BIT     3

// Diagnostic register bits
`define STO_DG_DISC_LSB    0
`define STO_DG_SELF_LSB    2
`define STO_DG_FBERR_BIT   4
`define STO_DG_BADADR_BIT  5
`define STO_DG_ADR0_BIT    6
`define STO_DG_PATH_BIT    7

// Address register layout
`define STO_AD_VALID_BIT   16

// Reset values
`define STO_ZERO_ADDR      10'h000
`define STO_ZERO_WORD      32'h0000_0000

`endif

// ---- sto_axis_path.v ----
// Hardwired safe input path of one axis: filter, discrepancy, self check
`timescale 1ns/1ps
`include "sto_enable_defs.vh"

module sto_axis_path #(
  parameter [`STO_CNT_W-1:0] PULSE_CYCLES = `STO_PULSE_CYC,
  parameter [`STO_CNT_W-1:0] DISC_CYCLES  = `STO_DISC_CYC
) (
  input  wire       clk_in,
  input  wire       nrst_in,
  input  wire [1:0] safe_in,
  input  wire       ack_in,
  output wire       hw_en_out,
  output wire       disc_err_out,
  output wire       self_err_out
);

  wire [1:0]            filt;
  wire [1:0]            self_mis;
  reg  [`STO_CNT_W-1:0] disc_cnt_r;
  reg                   disc_err_r;
  reg                   self_err_r;
  reg                   hw_en_r;

  // Per input: redundant capture and test pulse filter
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_in
      reg                   cap_a_r;
      reg                   cap_b_r;
      reg [`STO_CNT_W-1:0]  low_cnt_r;
      reg                   filt_r;

      // Two copies; a disagreement means a broken input stage
      always @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          cap_a_r <= 1'b0;
          cap_b_r <= 1'b0;
        end
        else
        begin
          cap_a_r <= safe_in[i];
          cap_b_r <= safe_in[i];
        end
      end

      // Low phases up to the pulse length are bridged
      always @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          low_cnt_r <= {`STO_CNT_W{1'b0}};
          filt_r    <= 1'b0;
        end
        else if (cap_a_r)
        begin
          low_cnt_r <= {`STO_CNT_W{1'b0}};
          filt_r    <= 1'b1;
        end
        else if (low_cnt_r >= PULSE_CYCLES)
          filt_r    <= 1'b0;
        else
          low_cnt_r <= low_cnt_r + 1'b1;
      end

      assign filt[i]     = filt_r;
      assign self_mis[i] = cap_a_r ^ cap_b_r;
    end
  endgenerate

  // Discrepancy timer, held at limit until the inputs agree
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      disc_cnt_r <= {`STO_CNT_W{1'b0}};
    else if (filt[0] == filt[1])
      disc_cnt_r <= {`STO_CNT_W{1'b0}};
    else if (disc_cnt_r < DISC_CYCLES)
      disc_cnt_r <= disc_cnt_r + 1'b1;
  end

  // Latched faults; a new fault wins over the acknowledge
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      disc_err_r <= 1'b0;
      self_err_r <= 1'b0;
    end
    else
    begin
      disc_err_r <= (disc_cnt_r >= DISC_CYCLES) | (disc_err_r & ~ack_in);
      self_err_r <= (|self_mis) | (self_err_r & ~ack_in);
    end
  end

  // Enable only when both filtered inputs are true
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      hw_en_r <= 1'b0;
    else
      hw_en_r <= filt[0] & filt[1];
  end

  assign hw_en_out    = hw_en_r;
  assign disc_err_out = disc_err_r;
  assign self_err_out = self_err_r;

endmodule // sto_axis_path

// ---- sto_enable_logic.v ----
// Top of the dual-source torque enable logic for two servo axes
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sto_enable_defs.vh"

module sto_enable_logic #(
  // Counts are pre-sized so the default fits the counter width
  parameter [`STO_CNT_W-1:0] PULSE_CYCLES =
    `STO_PULSE_CYC,
  parameter [`STO_CNT_W-1:0] DISC_CYCLES  =
    `STO_DISC_CYC
) (
  input  wire                    SYS_CLK_IN,
  input  wire                    NRST_IN,
  input  wire [1:0]              SAFE_INPUT_CONNECTOR_A_IN,
  input  wire [1:0]              SAFE_INPUT_CONNECTOR_B_IN,
  input  wire [`STO_ADDR_W-1:0]  ADDR_SWITCH_IN,
  input  wire                    FB_FRAME_VALID_IN,
  input  wire [`STO_ADDR_W-1:0]  FB_FRAME_ADDR_IN,
  input  wire [1:0]              FB_TORQUE_ENABLE_IN,
  input  wire                    FB_CONN_ERROR_IN,
  input  wire [`STO_RA_W-1:0]    REG_ADDR_IN,
  input  wire [`STO_RD_W-1:0]    REG_WDATA_IN,
  input  wire                    REG_WR_IN,
  input  wire                    REG_RD_IN,
  output wire [`STO_RD_W-1:0]    REG_RDATA_OUT,
  output wire [7:0]              TORQUE_OFF_PATH_OUT,
  output wire [1:0]              TORQUE_ENABLE_FEEDBACK_OUT,
  output wire                    STATUS_ERROR_OUT,
  output wire                    DIAG_EVENT_OUT,
  output wire [1:0]              BRAKE_OUT
);

  // Switch and fieldbus state
  reg  [`STO_ADDR_W-1:0] addr_r;
  reg                    addr_ok_r;
  reg  [1:0]             fb_en_r;
  reg                    fb_err_r;
  reg                    bad_addr_r;

  // Acknowledge, path fault and outputs
  reg                    ack_r;
  reg                    path_flt_r;
  reg  [1:0]             fbk_r;
  reg                    st_err_r;
  reg                    diag_ev_r;
  reg  [1:0]             brake_r;
  reg  [`STO_RD_W-1:0]   rdata_r;
  reg  [`STO_RD_W-1:0]   rdata_nxt;

  // Sticky diagnostics, plus the delayed card error for the event edge
  // Cleared by the same acknowledge as the faults
  reg                    dg_fberr_r;
  reg                    dg_badadr_r;
  reg                    dg_adr0_r;
  reg                    card_err_d_r;

  // Axis results
  // Indexed by axis: bit 0 connector A, bit 1 connector B
  wire [1:0]             hw_en;
  wire [1:0]             disc_err;
  wire [1:0]             self_err;
  wire [1:0]             axis_err;
  wire [1:0]             axis_en;
  wire                   card_err;
  wire                   ack_wr;
  wire                   frame_hit;
  wire [`STO_PI_W-1:0]   pi_in;
  wire [`STO_PI_W-1:0]   pi_out;
  wire [3:0]             pulse_in [0:1];

  // Per-path flip-flop outputs and the agreement check
  wire [7:0]             path_w;
  wire [1:0]             path_mis;

  // Switch read as binary every cycle; zero never qualifies
  // A switch moved while running takes effect one cycle later
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      addr_r    <= `STO_ZERO_ADDR;
      addr_ok_r <= 1'b0;
    end
    else
    begin
      addr_r    <= ADDR_SWITCH_IN;
      addr_ok_r <= (ADDR_SWITCH_IN != `STO_ZERO_ADDR);
    end
  end

  // A frame counts only when addressed to the switch setting
  // Comparing with the registered copy keeps one timing path
  assign frame_hit = FB_FRAME_VALID_IN & addr_ok_r &
                     (FB_FRAME_ADDR_IN == addr_r);

  // Fieldbus enables; a connection error drops them and clears by itself
  // No latched fault: the master side owns that acknowledge
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      fb_en_r    <= 2'b00;
      fb_err_r   <= 1'b0;
      bad_addr_r <= 1'b0;
    end
    else
    begin
      fb_err_r   <= FB_CONN_ERROR_IN;
      bad_addr_r <= FB_FRAME_VALID_IN & ~frame_hit;
      if (FB_CONN_ERROR_IN)
        fb_en_r <= 2'b00;
      else if (frame_hit)
        fb_en_r <= FB_TORQUE_ENABLE_IN;
    end
  end

  // Input pairs per axis
  // Kept as an array so the axis loop can index it
  assign pulse_in[0] = {2'b00, SAFE_INPUT_CONNECTOR_A_IN};
  assign pulse_in[1] = {2'b00, SAFE_INPUT_CONNECTOR_B_IN};

  // One hardwired path per axis
  // Both axes share the acknowledge; faults are kept per axis
  genvar ax;
  generate
    for (ax = 0; ax < `STO_AXES; ax = ax + 1)
    begin : g_axis
      sto_axis_path #(
        .PULSE_CYCLES (PULSE_CYCLES),
        .DISC_CYCLES  (DISC_CYCLES)
      ) u_path (
        .clk_in       (SYS_CLK_IN),
        .nrst_in      (NRST_IN),
        .safe_in      (pulse_in[ax][1:0]),
        .ack_in       (ack_r),
        .hw_en_out    (hw_en[ax]),
        .disc_err_out (disc_err[ax]),
        .self_err_out (self_err[ax])
      );

      // Either source suffices; a latched fault holds torque off
      assign axis_err[ax] = disc_err[ax] | self_err[ax];
      assign axis_en[ax]  = (hw_en[ax] | fb_en_r[ax]) & ~axis_err[ax] &
                            ~path_flt_r;

      // The four copies of one enable must agree; a split is a fault
      assign path_mis[ax] =
        (|path_w[ax*`STO_PATHS +: `STO_PATHS]) &
        ~(&path_w[ax*`STO_PATHS +: `STO_PATHS]);
    end
  endgenerate

  // Any latched fault is a card error for the status word
  assign card_err = (|axis_err) | path_flt_r;

  // Acknowledge needs control bit 7 together with the axis reset bit
  // Either bit alone is ignored
  assign ack_wr = REG_WR_IN & (REG_ADDR_IN == `STO_REG_CTRL) &
                  REG_WDATA_IN[`STO_CW_ACK_BIT] &
                  REG_WDATA_IN[`STO_CW_RESET_BIT];

  // Registered acknowledge pulse to the axis paths
  // Registering keeps the wide write decode off the fault flops
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      ack_r <= 1'b0;
    else
      ack_r <= ack_wr;
  end

  // Same value on all four paths of an axis, each path its own
  // flip-flop, so one stuck bit cannot hold the other three on
  genvar p;
  generate
    for (p = 0; p < `STO_AXES * `STO_PATHS; p = p + 1)
    begin : g_path
      reg path_bit_r;

      // Each path resets to torque off
      always @(posedge SYS_CLK_IN or negedge NRST_IN)
      begin
        if (!NRST_IN)
          path_bit_r <= 1'b0;
        else
          path_bit_r <= axis_en[p / `STO_PATHS];
      end

      assign path_w[p] = path_bit_r;
    end
  endgenerate

  // Disagreeing paths latch a card fault until acknowledged;
  // a split still present in the ack cycle wins over the clear
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      path_flt_r <= 1'b0;
    else
      path_flt_r <= (|path_mis) | (path_flt_r & ~ack_r);
  end

  // Feedback to the drive firmware, true means no torque-off
  // Taken from the same enable as the paths, so both agree
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      fbk_r <= 2'b00;
    else
      fbk_r <= axis_en;
  end

  // Status error bit follows the latched card fault
  // The event pulse marks only the rise, not the held fault
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      st_err_r     <= 1'b0;
      card_err_d_r <= 1'b0;
      diag_ev_r    <= 1'b0;
    end
    else
    begin
      st_err_r     <= card_err;
      card_err_d_r <= card_err;
      diag_ev_r    <= card_err & ~card_err_d_r;
    end
  end

  // Sticky fieldbus diagnostics; a new event wins over the acknowledge
  // A zero switch is flagged while it stands and kept until ack
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      dg_fberr_r  <= 1'b0;
      dg_badadr_r <= 1'b0;
      dg_adr0_r   <= 1'b0;
    end
    else
    begin
      dg_fberr_r  <= fb_err_r | (dg_fberr_r & ~ack_r);
      dg_badadr_r <= bad_addr_r | (dg_badadr_r & ~ack_r);
      dg_adr0_r   <= ~addr_ok_r | (dg_adr0_r & ~ack_r);
    end
  end

  // Brake outputs stay inert; the drive owns the brake
  // Kept as flip-flops so a later program can take them over
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      brake_r <= 2'b00;
    else
      brake_r <= 2'b00;
  end

  // Process images: only the two usable bytes are held
  // Remaining bytes of the seven-byte images carry no data here
  assign pi_in  = {{(`STO_PI_W-2){1'b0}}, fb_en_r};
  assign pi_out = {{(`STO_PI_W-2){1'b0}}, fbk_r};

  // Read mux; unmapped addresses return zero
  // Decoded from the live address; the strobe gates the capture
  always @*
  begin
    rdata_nxt = `STO_ZERO_WORD;
    case (REG_ADDR_IN)
      `STO_REG_CTRL:
        rdata_nxt = `STO_ZERO_WORD;
      `STO_REG_STATUS:
      begin
        rdata_nxt[`STO_ST_FB_A_BIT] = fbk_r[0];
        rdata_nxt[`STO_ST_FB_B_BIT] = fbk_r[1];
        rdata_nxt[`STO_ST_ERR_BIT]  = st_err_r;
      end
      `STO_REG_ADDR:
      begin
        rdata_nxt[`STO_ADDR_W-1:0]    = addr_r;
        rdata_nxt[`STO_AD_VALID_BIT]  = addr_ok_r;
      end
      `STO_REG_PI_IN:
        rdata_nxt[`STO_PI_W-1:0] = pi_in;
      `STO_REG_PI_OUT:
        rdata_nxt[`STO_PI_W-1:0] = pi_out;
      `STO_REG_DIAG:
      begin
        rdata_nxt[`STO_DG_DISC_LSB+1:`STO_DG_DISC_LSB] = disc_err;
        rdata_nxt[`STO_DG_SELF_LSB+1:`STO_DG_SELF_LSB] = self_err;
        rdata_nxt[`STO_DG_FBERR_BIT]  = dg_fberr_r;
        rdata_nxt[`STO_DG_BADADR_BIT] = dg_badadr_r;
        rdata_nxt[`STO_DG_ADR0_BIT]   = dg_adr0_r;
        rdata_nxt[`STO_DG_PATH_BIT]   = path_flt_r;
      end
      `STO_REG_SIZES:
      begin
        rdata_nxt[7:0]  = `STO_PI_BYTES;
        rdata_nxt[15:8] = `STO_PI_USE_BYTES;
      end
      default:
        rdata_nxt = `STO_ZERO_WORD;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  // Zero between reads so a stale word is never taken as fresh
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      rdata_r <= `STO_ZERO_WORD;
    else if (REG_RD_IN)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= `STO_ZERO_WORD;
  end

  // Outputs come straight from their flip-flops
  assign REG_RDATA_OUT              = rdata_r;
  assign TORQUE_OFF_PATH_OUT        = path_w;
  assign TORQUE_ENABLE_FEEDBACK_OUT = fbk_r;
  assign STATUS_ERROR_OUT           = st_err_r;
  assign DIAG_EVENT_OUT             = diag_ev_r;
  assign BRAKE_OUT                  = brake_r;

endmodule // sto_enable_logic

// ---- sto_enable_checker.sv ----
// Assertion checker for the torque enable logic top ports
`timescale 1ns/1ps
`include "sto_enable_defs.vh"

module sto_enable_checker #(
  parameter [`STO_CNT_W-1:0] PULSE_CYCLES = 26'd20,
  parameter [`STO_CNT_W-1:0] DISC_CYCLES  = 26'd100
) (
  input wire logic                   SYS_CLK_IN,
  input wire logic                   NRST_IN,
  input wire logic [1:0]             SAFE_INPUT_CONNECTOR_A_IN,
  input wire logic [1:0]             SAFE_INPUT_CONNECTOR_B_IN,
  input wire logic [`STO_ADDR_W-1:0] ADDR_SWITCH_IN,
  input wire logic                   FB_FRAME_VALID_IN,
  input wire logic [`STO_ADDR_W-1:0] FB_FRAME_ADDR_IN,
  input wire logic [1:0]             FB_TORQUE_ENABLE_IN,
  input wire logic                   FB_CONN_ERROR_IN,
  input wire logic [`STO_RA_W-1:0]   REG_ADDR_IN,
  input wire logic [`STO_RD_W-1:0]   REG_WDATA_IN,
  input wire logic                   REG_WR_IN,
  input wire logic                   REG_RD_IN,
  input wire logic [`STO_RD_W-1:0]   REG_RDATA_OUT,
  input wire logic [7:0]             TORQUE_OFF_PATH_OUT,
  input wire logic [1:0]             TORQUE_ENABLE_FEEDBACK_OUT,
  input wire logic                   STATUS_ERROR_OUT,
  input wire logic                   DIAG_EVENT_OUT,
  input wire logic [1:0]             BRAKE_OUT
);
  localparam int LIMIT = PULSE_CYCLES + DISC_CYCLES + 8;
  int   mis_a_r;
  int   mis_b_r;
  wire  ack_w = REG_WR_IN && REG_ADDR_IN == `STO_REG_CTRL
                && REG_WDATA_IN[8:7] == 2'b11;
  wire  hit_w = FB_FRAME_VALID_IN && FB_FRAME_ADDR_IN == ADDR_SWITCH_IN
                && ADDR_SWITCH_IN != 10'h000 && FB_TORQUE_ENABLE_IN[0];

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  // Run length of unequal raw inputs per connector
  always @(posedge SYS_CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      mis_a_r <= 0;
      mis_b_r <= 0;
    end
    else
    begin
      mis_a_r <= (^SAFE_INPUT_CONNECTOR_A_IN) ? mis_a_r + 1 : 0;
      mis_b_r <= (^SAFE_INPUT_CONNECTOR_B_IN) ? mis_b_r + 1 : 0;
    end
  end

  // Hit frame for axis A with the connection healthy for two cycles
  sequence fb_on_s;
    hit_w && !FB_CONN_ERROR_IN && $stable(ADDR_SWITCH_IN) && $past(NRST_IN)
    ##1 !FB_CONN_ERROR_IN;
  endsequence

  brake_idle_a: assert property (BRAKE_OUT == 2'b00)
    else $error("brake output driven");
  paths_agree_a: assert property (
    TORQUE_OFF_PATH_OUT[3:0] inside {4'h0, 4'hf}
    && TORQUE_OFF_PATH_OUT[7:4] inside {4'h0, 4'hf})
    else $error("torque paths of one axis differ");
  feedback_match_a: assert property (TORQUE_ENABLE_FEEDBACK_OUT ==
    {TORQUE_OFF_PATH_OUT[4], TORQUE_OFF_PATH_OUT[0]})
    else $error("feedback differs from paths");
  fb_enable_a: assert property (fb_on_s |=>
    (TORQUE_OFF_PATH_OUT[3:0] == 4'hf || STATUS_ERROR_OUT))
    else $error("fieldbus enable not applied");
  diag_pulse_a: assert property (DIAG_EVENT_OUT |=> !DIAG_EVENT_OUT)
    else $error("diagnostic event longer than a cycle");
  ack_release_a: assert property ($fell(STATUS_ERROR_OUT)
    |-> $past(ack_w, 3))
    else $error("error cleared without acknowledge");
  disc_latch_a: assert property ((mis_a_r >= LIMIT || mis_b_r >= LIMIT)
    |-> STATUS_ERROR_OUT)
    else $error("discrepancy not flagged");
  err_cause_a: assert property ($rose(STATUS_ERROR_OUT)
    |-> (mis_a_r >= DISC_CYCLES || mis_b_r >= DISC_CYCLES))
    else $error("error flag without discrepancy");
  addr_read_a: assert property (REG_RD_IN && REG_ADDR_IN == `STO_REG_ADDR
    && $stable(ADDR_SWITCH_IN) && $past(NRST_IN) |=> REG_RDATA_OUT ==
    {15'h0000, $past(ADDR_SWITCH_IN) != 10'h000, 6'h00,
    $past(ADDR_SWITCH_IN)})
    else $error("address register wrong");
  size_read_a: assert property (REG_RD_IN
    && REG_ADDR_IN == `STO_REG_SIZES |=> REG_RDATA_OUT == 32'h0000_0207)
    else $error("image sizes wrong");
endmodule // sto_enable_checker

// ---- sto_ctrl_model.sv ----
// Safety controller model: safe input levels and fieldbus frames
`timescale 1ns/1ps
`include "sto_enable_defs.vh"

module sto_ctrl_model (
  input  wire logic                   clk_in,
  output logic [1:0]             safe_a_out,
  output logic [1:0]             safe_b_out,
  output logic                   fb_valid_out,
  output logic [`STO_ADDR_W-1:0] fb_addr_out,
  output logic [1:0]             fb_en_out,
  output logic                   fb_err_out
);
  // Idle: inputs false, no frame
  initial
  begin
    safe_a_out = 2'b00;
    safe_b_out = 2'b00;
    fb_valid_out = 1'b0;
    fb_addr_out = 10'h000;
    fb_en_out = 2'b00;
    fb_err_out = 1'b0;
  end

  // One frame; fields inverted after so stale values never match
  task automatic frame(input logic [9:0] a, input logic [1:0] en);
    @(posedge clk_in);
    fb_valid_out <= 1'b1;
    fb_addr_out <= a;
    fb_en_out <= en;
    @(posedge clk_in);
    fb_valid_out <= 1'b0;
    fb_addr_out <= ~a;
    fb_en_out <= ~en;
  endtask

  task automatic set_safe(input int ax, input logic [1:0] v);
    @(posedge clk_in);
    if (ax == 0) safe_a_out <= v;
    else safe_b_out <= v;
  endtask

  // Low test pulse of len cycles on axis A; no limit is enforced here
  task automatic test_pulse(input int b, input int len);
    @(posedge clk_in);
    safe_a_out[b] <= 1'b0;
    repeat (len) @(posedge clk_in);
    safe_a_out[b] <= 1'b1;
  endtask

  task automatic set_err(input logic e);
    @(posedge clk_in);
    fb_err_out <= e;
  endtask
endmodule // sto_ctrl_model

// ---- sto_enable_logic_bench.sv ----
// Self-checking bench for the torque enable logic
`timescale 1ns/1ps
`include "sto_enable_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module sto_enable_logic_bench;
  localparam int PULSE = 20;
  localparam int DISC  = 100;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [9:0]  sw = 10'h000;
  logic [7:0]  ra = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rv;
  logic        drop_a = 1'b0;
  wire  [31:0] rdata;
  wire  [7:0]  path;
  wire  [1:0]  fb;
  wire  [1:0]  brk;
  wire  [1:0]  sa;
  wire  [1:0]  sb;
  wire  [9:0]  fa;
  wire  [1:0]  fe;
  wire         st;
  wire         ev;
  wire         fv;
  wire         fc;
  int          bad_count = 0;
  int          check_count = 0;
  int          ev_cnt = 0;

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  sto_ctrl_model ctl (.clk_in(clk), .safe_a_out(sa), .safe_b_out(sb),
    .fb_valid_out(fv), .fb_addr_out(fa), .fb_en_out(fe), .fb_err_out(fc));

  sto_enable_logic #(.PULSE_CYCLES(PULSE), .DISC_CYCLES(DISC)) dut (
    .SYS_CLK_IN(clk), .NRST_IN(nrst), .SAFE_INPUT_CONNECTOR_A_IN(sa),
    .SAFE_INPUT_CONNECTOR_B_IN(sb), .ADDR_SWITCH_IN(sw),
    .FB_FRAME_VALID_IN(fv), .FB_FRAME_ADDR_IN(fa),
    .FB_TORQUE_ENABLE_IN(fe), .FB_CONN_ERROR_IN(fc), .REG_ADDR_IN(ra),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .TORQUE_OFF_PATH_OUT(path),
    .TORQUE_ENABLE_FEEDBACK_OUT(fb), .STATUS_ERROR_OUT(st),
    .DIAG_EVENT_OUT(ev), .BRAKE_OUT(brk));

  // Monitors: axis A dropout and diagnostic pulses
  always @(posedge clk)
  begin
    if (path[0] !== 1'b1) drop_a <= 1'b1;
    if (ev === 1'b1) ev_cnt++;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic t_reset;
    `CHK("paths", 8'h00, path)
    `CHK("brake", 2'b00, brk)
    rd_reg(`STO_REG_SIZES);
    `CHK("sizes", 32'h0000_0207, rv)
    rd_reg(8'h1c);
    `CHK("unmapped", 32'h0000_0000, rv)
    $display("test reset done");
  endtask

  task automatic t_address;
    @(posedge clk) sw <= 10'h2a5;
    wait_cyc(3);
    rd_reg(`STO_REG_ADDR);
    `CHK("addr", 32'h0001_02a5, rv)
    @(posedge clk) sw <= 10'h000;
    wait_cyc(3);
    rd_reg(`STO_REG_ADDR);
    `CHK("addr zero", 32'h0000_0000, rv)
    ctl.frame(10'h000, 2'b11);
    wait_cyc(4);
    `CHK("zero frame", 8'h00, path)
    rd_reg(`STO_REG_DIAG);
    `CHK("diag addr", 2'b11, rv[6:5])
    @(posedge clk) sw <= 10'h3ff;
    ctl.frame(10'h3fe, 2'b01);
    wait_cyc(4);
    `CHK("other frame", 8'h00, path)
    ctl.frame(10'h3ff, 2'b01);
    wait_cyc(4);
    `CHK("fb paths", 8'h0f, path)
    `CHK("fb feedback", 2'b01, fb)
    rd_reg(`STO_REG_PI_IN);
    `CHK("image in", 32'h0000_0001, rv)
    rd_reg(`STO_REG_PI_OUT);
    `CHK("image out", 32'h0000_0001, rv)
    $display("test address done");
  endtask

  task automatic t_conn;
    ctl.set_err(1'b1);
    wait_cyc(4);
    `CHK("conn off", 8'h00, path)
    `CHK("conn status", 1'b0, st)
    ctl.set_err(1'b0);
    ctl.frame(10'h3ff, 2'b10);
    wait_cyc(4);
    `CHK("axis b", 8'hf0, path)
    ctl.frame(10'h3ff, 2'b00);
    wait_cyc(4);
    `CHK("fb off", 8'h00, path)
    $display("test connection done");
  endtask

  task automatic t_hw;
    ctl.set_safe(0, 2'b11);
    ctl.set_safe(1, 2'b11);
    wait_cyc(6);
    `CHK("hw on", 8'hff, path)
    @(posedge clk) drop_a <= 1'b0;
    ctl.test_pulse(0, PULSE);
    wait_cyc(6);
    `CHK("short pulse", 1'b0, drop_a)
    ctl.test_pulse(1, PULSE + 20);
    wait_cyc(6);
    `CHK("long pulse", 1'b1, drop_a)
    @(posedge clk) ev_cnt = 0;
    ctl.set_safe(0, 2'b01);
    wait_cyc(PULSE + DISC + 20);
    `CHK("disc status", 1'b1, st)
    `CHK("disc event", 1, ev_cnt)
    `CHK("disc paths", 8'hf0, path)
    rd_reg(`STO_REG_DIAG);
    `CHK("disc diag", 4'b0001, rv[3:0])
    rd_reg(`STO_REG_STATUS);
    `CHK("status word", 32'h0000_000a, rv)
    ctl.frame(10'h3ff, 2'b01);
    ctl.set_safe(0, 2'b11);
    wait_cyc(6);
    `CHK("latched", 8'hf0, path)
    wr_reg(`STO_REG_CTRL, 32'h0000_0080);
    wait_cyc(6);
    `CHK("half ack", 1'b1, st)
    wr_reg(`STO_REG_CTRL, 32'h0000_0180);
    wait_cyc(6);
    `CHK("acked", 1'b0, st)
    `CHK("restored", 8'hff, path)
    $display("test hardwired done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_address();
    t_conn();
    t_hw();
    conclude();
  end
endmodule // sto_enable_logic_bench

bind sto_enable_logic sto_enable_checker #(.PULSE_CYCLES(PULSE_CYCLES),
  .DISC_CYCLES(DISC_CYCLES)) chk (.SYS_CLK_IN(SYS_CLK_IN),
  .NRST_IN(NRST_IN), .SAFE_INPUT_CONNECTOR_A_IN(SAFE_INPUT_CONNECTOR_A_IN),
  .SAFE_INPUT_CONNECTOR_B_IN(SAFE_INPUT_CONNECTOR_B_IN),
  .ADDR_SWITCH_IN(ADDR_SWITCH_IN), .FB_FRAME_VALID_IN(FB_FRAME_VALID_IN),
  .FB_FRAME_ADDR_IN(FB_FRAME_ADDR_IN),
  .FB_TORQUE_ENABLE_IN(FB_TORQUE_ENABLE_IN),
  .FB_CONN_ERROR_IN(FB_CONN_ERROR_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .TORQUE_OFF_PATH_OUT(TORQUE_OFF_PATH_OUT),
  .TORQUE_ENABLE_FEEDBACK_OUT(TORQUE_ENABLE_FEEDBACK_OUT),
  .STATUS_ERROR_OUT(STATUS_ERROR_OUT), .DIAG_EVENT_OUT(DIAG_EVENT_OUT),
  .BRAKE_OUT(BRAKE_OUT));
